//--- csb_defs.svh
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH
`define CSB_RST_RELEASE_CLKS 2
`define CSB_SYNC_RST_VAL     1'b0
`define CSB_PIN_RST_VAL      1'b1
`define CSB_LIC_RST_VAL      1'b1
`define CSB_PIN_IDLE_VAL     4'hF
`define CSB_FLAG_RST_VAL     1'b0
`define CSB_WAIT_RST_VAL     2'h0
`endif

//--- csb_pkg.sv
package csb_pkg;
  typedef enum logic [2:0] {
    CSB_IDLE   = 3'b001,
    CSB_LOCKED = 3'b010,
    CSB_HALTED = 3'b100
  } csb_state_e;

  typedef struct packed {
    csb_state_e state;
    logic       fault_n;
    logic       halt_req;
    logic       halt_sent;
    logic       lock_n;
    logic       fp_pending;
    logic       fp_trap;
    logic       init_q;
    logic       init_pulse;
    logic       builtin_self_test_req;
    logic       strap_done;
    logic [1:0] strap_wait;
    logic       irq;
    logic       nmi;
    logic       lint0;
    logic       lint1;
  } csb_state_s;
endpackage : csb_pkg

//--- csb_sync.sv
`timescale 1ns/1ns
`include "csb_defs.svh"
// two flip-flop synchroniser, async pins inactive (high) after reset
module csb_sync (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic [3:0] i_async,
  output logic      [3:0] o_sync
);
  logic [3:0] meta_r;
  logic [3:0] sync_r;

  // first stage feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= `CSB_PIN_IDLE_VAL;
      sync_r <= `CSB_PIN_IDLE_VAL;
    end else if (i_ce) begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule : csb_sync

//--- csb_sideband.sv
`timescale 1ns/1ns
`include "csb_defs.svh"
// processor sideband: fault, numeric skip, soft init, local irq pins, lock
module csb_sideband (
  // clock, reset and enable
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // asynchronous pins, active low
  input  wire logic       i_skip_numeric_fault_n,
  input  wire logic       i_soft_init_n,
  input  wire logic [1:0] i_local_irq_pins,
  // core-side events and levels
  input  wire logic       i_fault_detect,
  input  wire logic       i_native_numeric_fault_enable,
  input  wire logic       i_local_irq_controller_en,
  input  wire logic       i_fp_error,
  input  wire logic       i_fp_instr,
  input  wire logic       i_lock_start,
  input  wire logic       i_lock_end,
  input  wire logic       i_halt_ack,
  input  wire logic       i_snoop_req,
  // bus-side and core-side outputs
  output logic            o_internal_fault_out_n,
  output logic            o_lock_n,
  output logic            o_halt_all_transaction,
  output logic            o_fp_trap,
  output logic            o_soft_init,
  output logic            o_builtin_self_test,
  output logic            o_snoop_ack,
  // local pin meanings
  output logic            o_maskable_irq_request,
  output logic            o_nmi,
  output logic            o_lint0,
  output logic            o_lint1
);
  logic                rst_meta_r;
  logic                rst_sync_r;
  logic                rst_n;
  logic [3:0]          pins_s;
  logic                skip_s;
  logic                init_s;
  logic                lint0_s;
  logic                lint1_s;
  logic                skip_honoured;
  logic                lock_may_open;
  logic                halt_due;
  logic                trap_due;
  csb_pkg::csb_state_s st_r;
  csb_pkg::csb_state_s st_nxt;

  // active-low pin copy to active-high level
  function automatic logic pin_active(input logic pin_n);
    pin_active = ~pin_n;
  endfunction : pin_active

  // one local pin steered to its controller or legacy meaning
  function automatic logic route_pin(input logic active, input logic lic_on, input logic legacy);
    route_pin = active & (legacy ? !lic_on : lic_on);
  endfunction : route_pin

  // reset release through two flops, frozen with the clock enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= `CSB_SYNC_RST_VAL;
      rst_sync_r <= `CSB_SYNC_RST_VAL;
    end else if (i_ce) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // all asynchronous pins synchronised
  csb_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_async   ({i_local_irq_pins, i_soft_init_n, i_skip_numeric_fault_n}),
    .o_sync    (pins_s)
  );

  // decoded pin levels, active high
  assign skip_s  = pin_active(pins_s[0]);
  assign init_s  = pin_active(pins_s[1]);
  assign lint0_s = pin_active(pins_s[2]);
  assign lint1_s = pin_active(pins_s[3]);

  // skip input counts only while the native enable bit is clear
  assign skip_honoured = skip_s & !i_native_numeric_fault_enable;

  // a faulting block never opens a new lock
  assign lock_may_open = i_lock_start & st_r.fault_n & !i_fault_detect;

  // halt still owed for a latched fault
  assign halt_due = !st_r.fault_n && !st_r.halt_sent;

  // noncontrol instruction meets an earlier error
  assign trap_due = i_fp_instr && st_r.fp_pending;

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.init_pulse = 1'b0;
    st_nxt.fp_trap    = 1'b0;

    // fault latches until reset
    if (i_fault_detect) begin
      st_nxt.fault_n = 1'b0;
      st_nxt.state   = csb_pkg::CSB_HALTED;
    end

    // one halt transaction per fault, held until core logic takes it
    if (halt_due) begin
      st_nxt.halt_req = 1'b1;
    end
    if (st_r.halt_req && i_halt_ack) begin
      st_nxt.halt_req  = 1'b0;
      st_nxt.halt_sent = 1'b1;
    end

    // numeric fault pending; a new error in the trap cycle stays pending
    if (i_fp_error) begin
      st_nxt.fp_pending = 1'b1;
    end
    if (trap_due) begin
      if (skip_honoured) begin
        st_nxt.fp_trap = 1'b0;
      end else begin
        st_nxt.fp_trap    = 1'b1;
        st_nxt.fp_pending = i_fp_error;
      end
    end

    // soft init edge restarts integer state; numeric state untouched
    st_nxt.init_q = init_s;
    if (init_s && !st_r.init_q) begin
      st_nxt.init_pulse = 1'b1;
    end

    // strap taken once the pin synchroniser has refilled after release
    if (!st_r.strap_done) begin
      if (st_r.strap_wait == 2'(`CSB_RST_RELEASE_CLKS)) begin
        st_nxt.strap_done = 1'b1;
        st_nxt.builtin_self_test_req   = init_s;
      end else begin
        st_nxt.strap_wait = st_r.strap_wait + 2'h1;
      end
    end

    // local irq pins: legacy meaning only with the controller off
    st_nxt.irq   = route_pin(lint0_s, i_local_irq_controller_en, 1'b1);
    st_nxt.nmi   = route_pin(lint1_s, i_local_irq_controller_en, 1'b1);
    st_nxt.lint0 = route_pin(lint0_s, i_local_irq_controller_en, 1'b0);
    st_nxt.lint1 = route_pin(lint1_s, i_local_irq_controller_en, 1'b0);

    // lock sequence tracking
    unique case (st_r.state)
      csb_pkg::CSB_IDLE: begin
        if (lock_may_open) begin
          st_nxt.state  = csb_pkg::CSB_LOCKED;
          st_nxt.lock_n = 1'b0;
        end
      end
      csb_pkg::CSB_LOCKED: begin
        if (i_lock_end) begin
          st_nxt.lock_n = 1'b1;
          if (st_nxt.state != csb_pkg::CSB_HALTED) begin
            st_nxt.state = csb_pkg::CSB_IDLE;
          end
        end
      end
      csb_pkg::CSB_HALTED: begin
        st_nxt.lock_n = 1'b1;
      end
    endcase
  end

  // state register; reset releases bus outputs at once
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.state      <= csb_pkg::CSB_IDLE;
      st_r.fault_n    <= `CSB_PIN_RST_VAL;
      st_r.halt_req   <= `CSB_FLAG_RST_VAL;
      st_r.halt_sent  <= `CSB_FLAG_RST_VAL;
      st_r.lock_n     <= `CSB_PIN_RST_VAL;
      st_r.fp_pending <= `CSB_FLAG_RST_VAL;
      st_r.fp_trap    <= `CSB_FLAG_RST_VAL;
      st_r.init_q     <= `CSB_FLAG_RST_VAL;
      st_r.init_pulse <= `CSB_FLAG_RST_VAL;
      st_r.builtin_self_test_req   <= `CSB_FLAG_RST_VAL;
      st_r.strap_done <= `CSB_FLAG_RST_VAL;
      st_r.strap_wait <= `CSB_WAIT_RST_VAL;
      st_r.irq        <= `CSB_FLAG_RST_VAL;
      st_r.nmi        <= `CSB_FLAG_RST_VAL;
      st_r.lint0      <= `CSB_FLAG_RST_VAL;
      st_r.lint1      <= `CSB_FLAG_RST_VAL;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // fault, halt and lock
  assign o_internal_fault_out_n = st_r.fault_n;
  assign o_lock_n               = st_r.lock_n;
  assign o_halt_all_transaction = st_r.halt_req;

  // numeric trap, soft init and self-test strap
  assign o_fp_trap              = st_r.fp_trap;
  assign o_soft_init            = st_r.init_pulse;
  assign o_builtin_self_test    = st_r.builtin_self_test_req;

  // snoops answered regardless of soft init
  assign o_snoop_ack            = i_snoop_req & rst_n;

  // local pin meanings
  assign o_maskable_irq_request = st_r.irq;
  assign o_nmi                  = st_r.nmi;
  assign o_lint0                = st_r.lint0;
  assign o_lint1                = st_r.lint1;
endmodule : csb_sideband

//--- csb_sideband_props.sv
`timescale 1ns/1ns
// port checker for the sideband block
module csb_sideband_props (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_fault_detect,
  input wire logic i_lock_start,
  input wire logic i_lock_end,
  input wire logic i_fp_instr,
  input wire logic i_snoop_req,
  input wire logic o_internal_fault_out_n,
  input wire logic o_lock_n,
  input wire logic o_halt_all_transaction,
  input wire logic o_fp_trap,
  input wire logic o_soft_init,
  input wire logic o_snoop_ack
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // fault, halt, lock, trap and init relations
  a_fault_sets: assert property (i_fault_detect |=> !o_internal_fault_out_n)
    else $error("fault not raised");
  a_fault_holds: assert property (!o_internal_fault_out_n |=> !o_internal_fault_out_n)
    else $error("fault dropped");
  a_halt_follows: assert property ($fell(o_internal_fault_out_n) |-> ##[0:2] o_halt_all_transaction)
    else $error("no halt");
  a_lock_opens: assert property (i_lock_start && o_internal_fault_out_n |-> ##[1:2] !o_lock_n)
    else $error("lock late");
  a_lock_closes: assert property (i_lock_end |-> ##[1:2] o_lock_n)
    else $error("lock stuck");
  a_trap_cause: assert property (o_fp_trap |-> $past(i_fp_instr))
    else $error("stray trap");
  a_init_pulse: assert property (o_soft_init |=> !o_soft_init)
    else $error("init too long");
  a_snoop_init: assert property (o_soft_init |-> o_snoop_ack == i_snoop_req)
    else $error("snoop lost");
endmodule : csb_sideband_props
bind csb_sideband csb_sideband_props u_props (.*);

//--- csb_core_model.sv
`timescale 1ns/1ns
// core logic: acks halt DLY+1 clocks after it rises, priority agent waits on lock
module csb_core_model #(parameter int DLY = 4) (
  input  wire logic i_ref_clk,
  input  wire logic i_halt,
  input  wire logic i_lock_n,
  input  wire logic i_prio_req,
  output logic      o_halt_ack,
  output logic      o_prio_grant
);
  int cnt = 0;
  // halt ack and lock-aware grant
  always @(posedge i_ref_clk) begin
    cnt <= (i_halt && !o_halt_ack) ? cnt + 1 : 0;
    o_halt_ack <= i_halt && cnt == DLY;
    o_prio_grant <= i_prio_req && i_lock_n;
  end
endmodule : csb_core_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic i_ref_clk = 0, i_rst_n = 0, i_ce = 1, i_fault_detect = 0, i_native_numeric_fault_enable = 0;
  logic i_skip_numeric_fault_n = 1, i_soft_init_n = 1, i_local_irq_controller_en = 1, i_fp_error = 0;
  logic i_fp_instr = 0, i_lock_start = 0, i_lock_end = 0, i_snoop_req = 0, i_halt_ack, prq = 0;
  logic [1:0] i_local_irq_pins = 2'h3;
  logic o_internal_fault_out_n, o_lock_n, o_halt_all_transaction, o_fp_trap, o_soft_init, gnt;
  logic o_builtin_self_test, o_snoop_ack, o_maskable_irq_request, o_nmi, o_lint0, o_lint1;
  int err_count = 0, comparisons = 0, traps = 0, inits = 0;
  csb_sideband DUT (.*);
  csb_core_model #(.DLY(4)) u_core (.i_ref_clk, .i_halt(o_halt_all_transaction), .i_lock_n(o_lock_n),
    .i_prio_req(prq), .o_halt_ack(i_halt_ack), .o_prio_grant(gnt));
  // clock and pulse counters
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    traps += o_fp_trap;
    inits += o_soft_init;
  end
  task automatic check(string n, logic [3:0] s, logic [3:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : cyc
  task automatic rst(logic ini);
    i_soft_init_n = ini;
    i_rst_n = 0;
    cyc(16);
    i_rst_n = 1;
    cyc(6);
    i_soft_init_n = 1;
    cyc(4);
  endtask : rst
  task automatic fp(int e);
    i_fp_error = 1;
    cyc(1);
    i_fp_error = 0;
    i_fp_instr = 1;
    cyc(1);
    i_fp_instr = 0;
    cyc(3);
    check("traps", traps, e);
  endtask : fp
  task automatic t_builtin_self_test;
    rst(0);
    check("builtin_self_test", o_builtin_self_test, 1);
    rst(1);
    check("builtin_self_test", o_builtin_self_test, 0);
    $display("t_builtin_self_test done");
  endtask : t_builtin_self_test
  task automatic t_irq;
    i_local_irq_pins = 2'h2;
    cyc(5);
    check("lint", {o_maskable_irq_request, o_nmi, o_lint0, o_lint1}, 4'h2);
    i_local_irq_controller_en = 0;
    cyc(5);
    check("irq", {o_maskable_irq_request, o_nmi, o_lint0, o_lint1}, 4'h8);
    i_local_irq_pins = 2'h1;
    cyc(5);
    check("nmi", {o_maskable_irq_request, o_nmi, o_lint0, o_lint1}, 4'h4);
    i_local_irq_pins = 2'h3;
    i_local_irq_controller_en = 1;
    $display("t_irq done");
  endtask : t_irq
  task automatic t_ce;
    i_ce = 0;
    i_local_irq_pins = 2'h2;
    cyc(5);
    check("ce", o_lint0, 0);
    i_ce = 1;
    cyc(5);
    check("ce", o_lint0, 1);
    i_local_irq_pins = 2'h3;
    cyc(4);
    $display("t_ce done");
  endtask : t_ce
  task automatic t_fp;
    i_skip_numeric_fault_n = 0;
    cyc(4);
    fp(0);
    i_native_numeric_fault_enable = 1;
    fp(1);
    i_native_numeric_fault_enable = 0;
    i_skip_numeric_fault_n = 1;
    cyc(4);
    fp(2);
    $display("t_fp done");
  endtask : t_fp
  task automatic t_init;
    inits = 0;
    i_snoop_req = 1;
    i_soft_init_n = 0;
    cyc(6);
    check("init", inits, 1);
    check("snoop", o_snoop_ack, 1);
    i_soft_init_n = 1;
    i_snoop_req = 0;
    cyc(4);
    $display("t_init done");
  endtask : t_init
  task automatic t_lock;
    i_lock_start = 1;
    cyc(1);
    i_lock_start = 0;
    prq = 1;
    cyc(3);
    check("lock", o_lock_n, 0);
    check("grant", gnt, 0);
    i_lock_end = 1;
    cyc(1);
    i_lock_end = 0;
    cyc(3);
    check("lock", o_lock_n, 1);
    check("grant", gnt, 1);
    prq = 0;
    $display("t_lock done");
  endtask : t_lock
  task automatic t_fault;
    i_fault_detect = 1;
    cyc(1);
    i_fault_detect = 0;
    cyc(2);
    check("halt", o_halt_all_transaction, 1);
    cyc(10);
    check("halt", o_halt_all_transaction, 0);
    check("fault", o_internal_fault_out_n, 0);
    i_rst_n = 0;
    cyc(2);
    check("fault", o_internal_fault_out_n, 1);
    check("lock", o_lock_n, 1);
    rst(1);
    check("fault", o_internal_fault_out_n, 1);
    $display("t_fault done");
  endtask : t_fault
  task automatic close_out;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    t_builtin_self_test;
    t_irq;
    t_ce;
    t_fp;
    t_init;
    t_lock;
    t_fault;
    close_out;
  end
  // watchdog
  initial begin
    #20000;
    err_count++;
    close_out;
  end
endmodule : tb_top
